// ---- ccdl_pkg.sv ----
/*
  Constants, field layout, register map and state encoding for the clock
  conditioning block's dynamic configuration loader.
  Assumes a single 20 MHz core clock and APB access from software.
*/
package ccdl_pkg;

  // ****************************************************************
  // Configuration image
  // ****************************************************************
  localparam int CFG_W = 89;
  localparam logic MIXED_VARIANT = 1'b1;
  localparam logic [6:0] FULL_LEN_MIXED = 7'h59;
  localparam logic [6:0] FULL_LEN_BASE = 7'h51;
  localparam logic [6:0] COUNT_MAX = 7'h7F;
  localparam logic [CFG_W-1:0] CFG_RST = 89'h0;
  localparam logic [CFG_W-1:0] DC_MASK = (89'h7 << 71) | (89'hF << 77);
  localparam logic [CFG_W-1:0] VARIANT_MASK = 89'hFF << 81;

  // Field positions
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 35;
  localparam int DLY_LSB = 35;
  localparam int DLY_W = 30;
  localparam int PH_LSB = 65;
  localparam int PH_W = 6;
  localparam int FIXDLY_BIT = 74;
  localparam int BYPASS_BIT = 75;
  localparam int OA_HALF_BIT = 84;
  localparam int OB_HALF_BIT = 85;
  localparam int OC_HALF_BIT = 86;
  localparam int GLMUX_LSB = 87;

  // ****************************************************************
  // APB register map
  // ****************************************************************
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] CFG0_OFS = 12'h008;
  localparam logic [11:0] CFG1_OFS = 12'h00C;
  localparam logic [11:0] CFG2_OFS = 12'h010;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam int ST_PARTIAL_BIT = 0;
  localparam int ST_OVERLAP_BIT = 1;

  // Clock source choices
  localparam logic [1:0] SRC_SEL0 = 2'h0;
  localparam logic [1:0] SRC_SEL1 = 2'h1;
  localparam logic [1:0] SRC_SEL2 = 2'h2;
  localparam logic [1:0] SRC_INTERNAL = 2'h3;

  // Loader states, Gray coded along idle-shift-hold-apply
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_SHIFT = 2'b01,
    LD_HOLD = 2'b11,
    LD_APPLY = 2'b10
  } ccdl_ld_state_t;

endpackage

// ---- ccdl_sync.sv ----
/*
  Two-stage synchroniser for a bundle of independent level inputs.
  Assumes each bit changes slowly relative to the core clock.
*/
module ccdl_sync
  import ccdl_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // ****************************************************************
  // Two flops; the first is read only by the second
  // ****************************************************************
  always_comb begin
    meta_next = d_in;
    q_next = meta_reg;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q_out = q_reg;

endmodule

// ---- ccdl_shift_reg.sv ----
/*
  Serial configuration shift register, filled from the top bit downward.
  Assumes shift_in is a one-cycle pulse per accepted shift clock edge.
*/
module ccdl_shift_reg
  import ccdl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic shift_in,
  input wire logic serial_config_in_in,
  output logic [CFG_W-1:0] data_out
);

  logic [CFG_W-1:0] data_reg;
  logic [CFG_W-1:0] data_next;

  // ****************************************************************
  // Shift path
  // ****************************************************************
  // one bit per pulse
  always_comb begin
    data_next = data_reg;
    if (shift_in) begin
      data_next = {serial_config_in_in, data_reg[CFG_W-1:1]};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      data_reg <= CFG_RST;
    end else begin
      data_reg <= data_next;
    end
  end

  assign data_out = data_reg;

endmodule

// ---- ccdl_top.sv ----
/*
  Dynamic configuration loader for the clock conditioning block, with the
  global input source selector and an APB register slave.
  Assumes the loader pins and pads come from outside the core clock domain
  and change no faster than a quarter of the 20 MHz core clock.
*/
module ccdl_top
  import ccdl_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic NRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic PREADY_OUT,
  output logic [31:0] PRDATA_OUT,
  output logic PSLVERR_OUT,
  input wire logic CONFIG_SHIFT_CLOCK_IN,
  input wire logic SERIAL_CONFIG_IN,
  input wire logic CONFIG_SHIFT_ENABLE_IN,
  input wire logic CONFIG_UPDATE_STROBE_IN,
  input wire logic [3:0] GLOBAL_PAD_IN,
  input wire logic PAIR_IO_IN,
  input wire logic INTERNAL_CLOCK_IN,
  output logic [1:0] OUTPUT_MUX_SOURCE_SELECT_OUT,
  output logic OUT_A_HALF_STEP_DIVIDE_OUT,
  output logic OUT_B_HALF_STEP_DIVIDE_OUT,
  output logic OUT_C_HALF_STEP_DIVIDE_OUT,
  output logic [DIV_W-1:0] DIVIDER_SETTING_OUT,
  output logic [DLY_W-1:0] DELAY_SETTING_OUT,
  output logic [PH_W-1:0] PHASE_SELECT_OUT,
  output logic FIXED_DELAY_EN_OUT,
  output logic PLL_BYPASS_OUT,
  output logic SELECTED_CLOCK_OUT,
  output logic [3:0] PAD_AS_IO_OUT,
  output logic CONFIG_BUSY_OUT
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [3:0] ld_s;
  logic [5:0] pad_s;
  logic sclk_s;
  logic serial_config_in_s;
  logic en_s;
  logic upd_s;

  // loader pins from bridge, core or I/O
  ccdl_sync #(.W(4)) u_ld_sync (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(NRST_IN),
    .d_in({CONFIG_UPDATE_STROBE_IN, CONFIG_SHIFT_ENABLE_IN, SERIAL_CONFIG_IN,
           CONFIG_SHIFT_CLOCK_IN}),
    .q_out(ld_s)
  );

  ccdl_sync #(.W(6)) u_pad_sync (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(NRST_IN),
    .d_in({INTERNAL_CLOCK_IN, PAIR_IO_IN, GLOBAL_PAD_IN}),
    .q_out(pad_s)
  );

  assign sclk_s = ld_s[0];
  assign serial_config_in_s = ld_s[1];
  assign en_s = ld_s[2];
  assign upd_s = ld_s[3];

  // ****************************************************************
  // Edge detection and shift register
  // ****************************************************************
  logic sclk_d_reg;
  logic sclk_d_next;
  logic upd_d_reg;
  logic upd_d_next;
  logic shift_pulse;
  logic upd_rise;
  logic [CFG_W-1:0] shift_data;

  // Previous levels for edge detection
  always_comb begin
    sclk_d_next = sclk_s;
    upd_d_next = upd_s;
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!NRST_IN) begin
      sclk_d_reg <= 1'b0;
      upd_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_d_next;
      upd_d_reg <= upd_d_next;
    end
  end

  // rising shift clock with enable high
  assign shift_pulse = sclk_s & ~sclk_d_reg & en_s;
  assign upd_rise = upd_s & ~upd_d_reg;

  ccdl_shift_reg u_shift (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(NRST_IN),
    .shift_in(shift_pulse),
    .serial_config_in_in(serial_config_in_s),
    .data_out(shift_data)
  );

  // ****************************************************************
  // Loader state, bit count and active image
  // ****************************************************************
  ccdl_ld_state_t state_reg;
  ccdl_ld_state_t state_next;
  logic [6:0] count_reg;
  logic [6:0] count_next;
  logic [CFG_W-1:0] cfg_reg;
  logic [CFG_W-1:0] cfg_next;
  logic partial_reg;
  logic partial_next;
  logic overlap_reg;
  logic overlap_next;
  logic upd_try;
  logic full_ok;
  logic apply_ok;
  logic [2:0] ctrl_reg;
  logic [2:0] ctrl_next;
  logic apb_wr;
  logic [31:0] apb_wdata;
  logic [11:0] apb_addr;

  // full image length depends on variant
  assign full_ok = count_reg >= (MIXED_VARIANT ? FULL_LEN_MIXED : FULL_LEN_BASE);
  // update only with shift enable low
  assign upd_try = upd_rise & ~en_s;
  assign apply_ok = upd_try & full_ok;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    cfg_next = cfg_reg;
    partial_next = partial_reg;
    overlap_next = overlap_reg;
    // Write one to clear; a new event in the same cycle wins
    if (apb_wr && apb_addr == STATUS_OFS) begin
      partial_next = partial_reg & ~apb_wdata[ST_PARTIAL_BIT];
      overlap_next = overlap_reg & ~apb_wdata[ST_OVERLAP_BIT];
    end
    // Saturate so a runaway loader cannot wrap back to a short count
    if (shift_pulse && count_reg != COUNT_MAX) begin
      count_next = count_reg + 7'h1;
    end
    case (state_reg)
      LD_IDLE: begin
        if (shift_pulse) begin
          state_next = LD_SHIFT;
        end
      end
      LD_SHIFT: begin
        if (!en_s) begin
          state_next = LD_HOLD;
        end
      end
      LD_HOLD: begin
        if (en_s) begin
          state_next = LD_SHIFT;
        end else if (upd_try) begin
          state_next = LD_APPLY;
        end
      end
      default: begin
        state_next = LD_IDLE;
      end
    endcase
    // strobe during shifting is refused and flagged
    if (upd_rise && en_s) begin
      overlap_next = 1'b1;
    end
    // a short load is refused, image kept
    if (upd_try && !full_ok) begin
      partial_next = 1'b1;
    end
    // image replaced only on accepted update
    if (apply_ok) begin
      // don't care bits stored as zero; variant bits
      cfg_next = shift_data & ~DC_MASK & (MIXED_VARIANT ? '1 : ~VARIANT_MASK);
      count_next = 7'h0;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!NRST_IN) begin
      state_reg <= LD_IDLE;
      count_reg <= 7'h0;
      cfg_reg <= CFG_RST;
      partial_reg <= 1'b0;
      overlap_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      cfg_reg <= cfg_next;
      partial_reg <= partial_next;
      overlap_reg <= overlap_next;
    end
  end

  // ****************************************************************
  // Decoded outputs and clock source selection
  // ****************************************************************
  logic [1:0] mux_reg;
  logic [1:0] mux_next;
  logic [2:0] half_reg;
  logic [2:0] half_next;
  logic sel_clk_reg;
  logic sel_clk_next;
  logic [3:0] pad_io_reg;
  logic [3:0] pad_io_next;
  logic busy_reg;
  logic busy_next;

  always_comb begin
    mux_next = cfg_reg[GLMUX_LSB +: 2];
    half_next = {cfg_reg[OC_HALF_BIT], cfg_reg[OB_HALF_BIT], cfg_reg[OA_HALF_BIT]}
                & {3{cfg_reg[BYPASS_BIT]}};
    busy_next = state_next != LD_IDLE;
    sel_clk_next = pad_s[5];
    pad_io_next = 4'hF;
    if (ctrl_reg[1:0] == SRC_INTERNAL) begin
      sel_clk_next = pad_s[5];
    end else if (ctrl_reg[2]) begin
      // differential pairs: pads 1/2 or pad 3/IO
      if (ctrl_reg[1:0] == SRC_SEL0) begin
        sel_clk_next = pad_s[0] & ~pad_s[1];
        pad_io_next = 4'hC;
      end else begin
        sel_clk_next = pad_s[2] & ~pad_s[4];
        pad_io_next = 4'hB;
      end
    end else begin
      // single-ended: pad one, two or four
      if (ctrl_reg[1:0] == SRC_SEL0) begin
        sel_clk_next = pad_s[0];
        pad_io_next = 4'hE;
      end else if (ctrl_reg[1:0] == SRC_SEL1) begin
        sel_clk_next = pad_s[1];
        pad_io_next = 4'hD;
      end else begin
        sel_clk_next = pad_s[3];
        pad_io_next = 4'h7;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!NRST_IN) begin
      mux_reg <= 2'h0;
      half_reg <= 3'h0;
      sel_clk_reg <= 1'b0;
      pad_io_reg <= 4'hF;
      busy_reg <= 1'b0;
    end else begin
      mux_reg <= mux_next;
      half_reg <= half_next;
      sel_clk_reg <= sel_clk_next;
      pad_io_reg <= pad_io_next;
      busy_reg <= busy_next;
    end
  end

  assign OUTPUT_MUX_SOURCE_SELECT_OUT = mux_reg;
  assign OUT_A_HALF_STEP_DIVIDE_OUT = half_reg[0];
  assign OUT_B_HALF_STEP_DIVIDE_OUT = half_reg[1];
  assign OUT_C_HALF_STEP_DIVIDE_OUT = half_reg[2];
  // five dividers; delays and phase selects
  assign DIVIDER_SETTING_OUT = cfg_reg[DIV_LSB +: DIV_W];
  assign DELAY_SETTING_OUT = cfg_reg[DLY_LSB +: DLY_W];
  assign PHASE_SELECT_OUT = cfg_reg[PH_LSB +: PH_W];
  assign FIXED_DELAY_EN_OUT = cfg_reg[FIXDLY_BIT];
  assign PLL_BYPASS_OUT = cfg_reg[BYPASS_BIT];
  assign SELECTED_CLOCK_OUT = sel_clk_reg;
  assign PAD_AS_IO_OUT = pad_io_reg;
  assign CONFIG_BUSY_OUT = busy_reg;

  // ****************************************************************
  // APB slave, zero wait states
  // ****************************************************************
  logic pready_reg;
  logic pready_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;

  assign apb_wr = PSEL_IN & PENABLE_IN & pready_reg & PWRITE_IN & ~pslverr_reg;
  assign apb_wdata = PWDATA_IN;
  assign apb_addr = PADDR_IN;

  // Read data latched in the setup phase so it leaves a flop
  always_comb begin
    pready_next = PSEL_IN & ~PENABLE_IN;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    ctrl_next = ctrl_reg;
    if (PSEL_IN && !PENABLE_IN) begin
      prdata_next = 32'h0;
      if (PADDR_IN == CTRL_OFS) begin
        prdata_next[2:0] = ctrl_reg;
      end else if (PADDR_IN == STATUS_OFS) begin
        prdata_next = {14'h0, state_reg, 1'b0, count_reg, 4'h0, MIXED_VARIANT,
                       busy_reg, overlap_reg, partial_reg};
      end else if (PADDR_IN == CFG0_OFS) begin
        prdata_next = cfg_reg[31:0];
      end else if (PADDR_IN == CFG1_OFS) begin
        prdata_next = cfg_reg[63:32];
      end else if (PADDR_IN == CFG2_OFS) begin
        prdata_next = {7'h0, cfg_reg[88:64]};
      end else begin
        pslverr_next = 1'b1;
      end
    end
    if (apb_wr && apb_addr == CTRL_OFS) begin
      ctrl_next = apb_wdata[2:0];
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!NRST_IN) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
      ctrl_reg <= CTRL_RST;
    end else begin
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      ctrl_reg <= ctrl_next;
    end
  end

  assign PREADY_OUT = pready_reg;
  assign PRDATA_OUT = prdata_reg;
  assign PSLVERR_OUT = pslverr_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!NRST_IN);

  a_shift_takes_bit: assert property (
    shift_pulse |=> shift_data[CFG_W-1] == $past(serial_config_in_s) && count_reg == ($past(count_reg) ==
      COUNT_MAX ? COUNT_MAX : $past(count_reg) + 7'h1))
    else $error("shift did not take serial bit");
  a_shift_holds: assert property (
    !shift_pulse |=> shift_data == $past(shift_data))
    else $error("shift register moved without pulse");
  a_cfg_steady: assert property (
    !apply_ok |=> cfg_reg == $past(cfg_reg))
    else $error("active image changed without update");
  a_apply_image: assert property (
    apply_ok |=> cfg_reg == ($past(shift_data) & ~DC_MASK) && count_reg == 7'h0)
    else $error("applied image wrong");
  a_partial_refused: assert property (
    upd_try && !full_ok |=> partial_reg && cfg_reg == $past(cfg_reg))
    else $error("partial load not refused");
  a_overlap_flag: assert property (
    upd_rise && en_s |=> overlap_reg && cfg_reg == $past(cfg_reg))
    else $error("update during shift not refused");
  a_mux_follows: assert property (
    apply_ok |-> ##2 mux_reg == $past(shift_data[GLMUX_LSB +: 2], 2))
    else $error("output mux select wrong");
  a_half_gated: assert property (
    !cfg_reg[BYPASS_BIT] |=> half_reg == 3'h0)
    else $error("half-step divide without bypass");
  a_apb_zero_wait: assert property (
    PSEL_IN && !PENABLE_IN |=> pready_reg ##1 !pready_reg || (PSEL_IN && !PENABLE_IN))
    else $error("APB answer timing wrong");
  a_internal_src: assert property (
    ctrl_reg[1:0] == SRC_INTERNAL && $stable(ctrl_reg) |=> sel_clk_reg == $past(pad_s[5]))
    else $error("internal clock not selected");

  c_full_apply: cover property (apply_ok);
  c_partial: cover property (upd_try && !full_ok);
  c_overlap: cover property (upd_rise && en_s);
  c_apb_write: cover property (apb_wr && apb_addr == CTRL_OFS);

endmodule

// ---- ccdl_loader_model.sv ----
/*
  Behavioural core-logic loader driving the configuration pins.
  Assumes a free-running core clock; a command is a one-cycle go pulse.
*/
module ccdl_loader_model
  import ccdl_pkg::*;
(
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [7:0] nbits_in,
  input wire logic [CFG_W-1:0] img_in,
  input wire logic bad_strobe_in,
  output logic sclk_out,
  output logic sdata_out,
  output logic shift_en_out,
  output logic strobe_out,
  output logic done_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle pins; shift clock stands low outside frames
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    shift_en_out = 1'b0;
    strobe_out = 1'b0;
    done_out = 1'b0;
  end

  // Four core cycles per phase, so data is stable well around each rise
  always begin
    @(posedge clk_in);
    if (go_in === 1'b1) begin
      for (int i = 0; i < int'(nbits_in); i++) begin
        sdata_out <= img_in[i];
        shift_en_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        sclk_out <= 1'b1;
        if (bad_strobe_in && i == int'(nbits_in) - 1) begin
          strobe_out <= 1'b1;
        end
        repeat (4) @(posedge clk_in);
        sclk_out <= 1'b0;
      end
      repeat (4) @(posedge clk_in);
      shift_en_out <= 1'b0;
      strobe_out <= 1'b0;
      sdata_out <= ~sdata_out; // Released line shows no stale bit
      repeat (4) @(posedge clk_in);
      if (!bad_strobe_in) begin
        strobe_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        strobe_out <= 1'b0;
      end
      repeat (12) @(posedge clk_in);
      done_out <= 1'b1;
      @(posedge clk_in);
      done_out <= 1'b0;
    end
  end
endmodule

// ---- ccdl_top_bench.sv ----
/*
  Self-checking bench: APB master tasks plus the loader model.
  Assumes the loader top answers APB with zero wait states.
*/
module ccdl_top_bench
  import ccdl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Stimulus and wiring
  // ****************************************************************
  localparam logic [CFG_W-1:0] IMG1 = {2'b10, 3'b111, 3'b110, 4'hF, 3'b110, 3'h7,
    6'h2D, 30'h2AAA5555, 35'h412345678};
  localparam logic [CFG_W-1:0] IMG2 = {2'b01, 3'b111, 3'b001, 4'h0, 3'b001, 3'h0,
    6'h12, 30'h1555AAAA, 35'h3EDCBA987};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pads = 4'h5;
  logic pair_io = 1'b0;
  logic int_clk = 1'b1;
  logic go = 1'b0;
  logic [7:0] nbits = 8'h00;
  logic [CFG_W-1:0] img = '0;
  logic bad = 1'b0;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int comparisons = 0;
  wire sclk, sdata, sen, supd, ld_done, pready, pslverr, bypass, fixdly, selclk, busy;
  wire oa, ob, oc;
  wire [1:0] mux;
  wire [31:0] prdata;
  wire [DIV_W-1:0] div;
  wire [DLY_W-1:0] dly;
  wire [PH_W-1:0] ph;
  wire [3:0] pad_io;

  // Clock, 50 ns period
  always #25 clk = ~clk;

  ccdl_top DUT (.CORE_CLK_IN(clk), .NRST_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready),
    .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .CONFIG_SHIFT_CLOCK_IN(sclk),
    .SERIAL_CONFIG_IN(sdata), .CONFIG_SHIFT_ENABLE_IN(sen), .CONFIG_UPDATE_STROBE_IN(supd),
    .GLOBAL_PAD_IN(pads), .PAIR_IO_IN(pair_io), .INTERNAL_CLOCK_IN(int_clk),
    .OUTPUT_MUX_SOURCE_SELECT_OUT(mux), .OUT_A_HALF_STEP_DIVIDE_OUT(oa),
    .OUT_B_HALF_STEP_DIVIDE_OUT(ob), .OUT_C_HALF_STEP_DIVIDE_OUT(oc),
    .DIVIDER_SETTING_OUT(div), .DELAY_SETTING_OUT(dly), .PHASE_SELECT_OUT(ph),
    .FIXED_DELAY_EN_OUT(fixdly), .PLL_BYPASS_OUT(bypass), .SELECTED_CLOCK_OUT(selclk),
    .PAD_AS_IO_OUT(pad_io), .CONFIG_BUSY_OUT(busy));

  ccdl_loader_model LOADER (.clk_in(clk), .go_in(go), .nbits_in(nbits), .img_in(img),
    .bad_strobe_in(bad), .sclk_out(sclk), .sdata_out(sdata), .shift_en_out(sen),
    .strobe_out(supd), .done_out(ld_done));

  // ****************************************************************
  // Tasks and reference functions
  // ****************************************************************
  task automatic test_done();
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [CFG_W-1:0] seen, input logic [CFG_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      failures++;
      test_done();
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(CFG_W'(rd & m), CFG_W'(e));
  endtask

  // Loader command; bounded wait for the model's done pulse
  task automatic load(input logic [CFG_W-1:0] im, input logic [7:0] n, input logic b);
    int k;
    @(posedge clk);
    img <= im;
    nbits <= n;
    bad <= b;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 2000; k++) begin
      @(posedge clk);
      if (ld_done === 1'b1) break;
    end
    if (k == 2000) begin
      failures++;
      test_done();
    end
  endtask

  // Busy stays high while a shifted image waits for its update
  task automatic check_out(input logic [CFG_W-1:0] e, input logic eb);
    check(CFG_W'(mux), CFG_W'(e[GLMUX_LSB+:2]));
    check(CFG_W'(oc), CFG_W'(e[OC_HALF_BIT] & e[BYPASS_BIT]));
    check(CFG_W'(ob), CFG_W'(e[OB_HALF_BIT] & e[BYPASS_BIT]));
    check(CFG_W'(oa), CFG_W'(e[OA_HALF_BIT] & e[BYPASS_BIT]));
    check(CFG_W'({div, dly, ph, fixdly, bypass, busy}), CFG_W'({e[DIV_LSB+:DIV_W],
      e[DLY_LSB+:DLY_W], e[PH_LSB+:PH_W], e[FIXDLY_BIT], e[BYPASS_BIT], eb}));
    rd_chk(CFG0_OFS, 32'hFFFFFFFF, e[31:0]);
    rd_chk(CFG1_OFS, 32'hFFFFFFFF, e[63:32]);
    rd_chk(CFG2_OFS, 32'hFFFFFFFF, {7'h0, e[88:64]});
  endtask

  // Pads left free for each source choice
  function automatic logic [3:0] exp_free(input logic [2:0] c);
    if (c[1:0] == SRC_INTERNAL) return 4'hF;
    if (c[2]) return (c[1:0] == SRC_SEL0) ? 4'hC : 4'hB;
    return (c[1:0] == SRC_SEL0) ? 4'hE : (c[1:0] == SRC_SEL1) ? 4'hD : 4'h7;
  endfunction

  function automatic logic exp_sel(input logic [2:0] c, input logic [3:0] p,
                                   input logic io, input logic ic);
    if (c[1:0] == SRC_INTERNAL) return ic;
    if (c[2]) return (c[1:0] == SRC_SEL0) ? (p[0] & ~p[1]) : (p[2] & ~io);
    return (c[1:0] == SRC_SEL0) ? p[0] : (c[1:0] == SRC_SEL1) ? p[1] : p[3];
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // Watchdog against a hang anywhere
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge clk);
    #1;
    check(CFG_W'({pad_io, mux, busy, bypass, oa}), CFG_W'(9'h1E0));
    @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(STATUS_OFS, 32'hFFFFFFFF, 32'h8);
    rd_chk(CTRL_OFS, 32'hFFFFFFFF, 32'h0);
    apb(1'b1, 12'h100, 32'hFFFFFFFF);
    check(CFG_W'(err), CFG_W'(1'b1));
    rd_chk(12'h100, 32'hFFFFFFFF, 32'h0);
    check(CFG_W'(err), CFG_W'(1'b1));
    apb(1'b1, CTRL_OFS, 32'hFFFFFFFF);
    rd_chk(CTRL_OFS, 32'hFFFFFFFF, 32'h7);
    // Every source and standard, three pad patterns each
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, CTRL_OFS, 32'(c));
      for (int j = 0; j < 3; j++) begin
        pads <= (j == 1) ? 4'hA : 4'h5;
        pair_io <= (j > 0);
        int_clk <= (j != 1);
        repeat (8) @(posedge clk);
        check(CFG_W'(pad_io), CFG_W'(exp_free(3'(c))));
        check(CFG_W'(selclk), CFG_W'(exp_sel(3'(c), pads, pair_io, int_clk)));
      end
    end
    load(IMG1, 8'd89, 1'b0);
    check_out(IMG1 & ~DC_MASK, 1'b0);
    rd_chk(STATUS_OFS, 32'hF, 32'h8);
    load(IMG2, 8'd40, 1'b0);
    rd_chk(STATUS_OFS, 32'hF, 32'h9);
    check_out(IMG1 & ~DC_MASK, 1'b0);
    apb(1'b1, STATUS_OFS, 32'h3);
    rd_chk(STATUS_OFS, 32'hF, 32'h8);
    load(IMG2, 8'd89, 1'b1);
    rd_chk(STATUS_OFS, 32'hF, 32'hE);
    check_out(IMG1 & ~DC_MASK, 1'b1);
    apb(1'b1, STATUS_OFS, 32'h3);
    load(IMG2, 8'd89, 1'b0);
    check_out(IMG2 & ~DC_MASK, 1'b0);
    rd_chk(STATUS_OFS, 32'hF, 32'h8);
    test_done();
  end
endmodule
